// [sbta_pkg.sv]
// constants and types shared by the sixteen-bit timer files
package sbta_pkg;

  // ----------------------------------------------------------------
  // register word indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL_A = 4'h0;
  localparam logic [3:0] IDX_CTRL_B = 4'h1;
  localparam logic [3:0] IDX_CNT_LO = 4'h2;
  localparam logic [3:0] IDX_CNT_HI = 4'h3;
  localparam logic [3:0] IDX_CMPA_LO = 4'h4;
  localparam logic [3:0] IDX_CMPA_HI = 4'h5;
  localparam logic [3:0] IDX_CMPB_LO = 4'h6;
  localparam logic [3:0] IDX_CMPB_HI = 4'h7;
  localparam logic [3:0] IDX_CAP_LO = 4'h8;
  localparam logic [3:0] IDX_CAP_HI = 4'h9;
  localparam logic [3:0] IDX_FLAG = 4'hA;
  localparam logic [3:0] IDX_MASK = 4'hB;
  localparam logic [3:0] IDX_LAST = 4'hB;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CA_MODE_LO = 0;
  localparam int CA_COM_B = 4;
  localparam int CA_COM_A = 6;
  localparam int CB_CLK_SEL = 0;
  localparam int CB_MODE_HI = 3;
  localparam int CB_CAP_SRC = 5;
  localparam int CB_CAP_EDGE = 6;
  localparam int CB_FILTER = 7;
  localparam int FL_OVF = 0;
  localparam int FL_MATCH_A = 1;
  localparam int FL_MATCH_B = 2;
  localparam int FL_CAPTURE = 3;

  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] COUNT_FLOOR = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] PEAK_8 = 16'h00FF;
  localparam logic [15:0] PEAK_9 = 16'h01FF;
  localparam logic [15:0] PEAK_10 = 16'h03FF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // clock selection and input filter
  // ----------------------------------------------------------------
  localparam int PRE_W = 10;
  localparam int FILT_LEN = 4;
  typedef enum logic [2:0] {
    CS_OFF, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
  } sbta_clk_sel_t;

endpackage

// [sbta_clk_sel.sv]
// timer clock selection: prescaler taps and external count pin edge
`timescale 1ns/1ns
module sbta_clk_sel
  import sbta_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [2:0] clk_select,
  input wire logic ext_count_pin,
  output logic tick
);
  import sbta_pkg::*;

  logic [PRE_W-1:0] pre_r;
  logic sync1_r, sync2_r, prev_r;
  sbta_clk_sel_t sel;

  assign sel = sbta_clk_sel_t'(clk_select);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pre_r <= '0;
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else if (ce)
    begin
      pre_r <= pre_r + 1'b1;
      sync1_r <= ext_count_pin;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // ----------------------------------------------------------------
  // tick selection
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (sel)
      CS_OFF: tick = 1'b0;
      CS_DIV1: tick = ce;
      CS_DIV8: tick = ce && (&pre_r[2:0]);
      CS_DIV64: tick = ce && (&pre_r[5:0]);
      CS_DIV256: tick = ce && (&pre_r[7:0]);
      CS_DIV1024: tick = ce && (&pre_r[9:0]);
      CS_EXT_FALL: tick = ce && prev_r && !sync2_r;
      CS_EXT_RISE: tick = ce && !prev_r && sync2_r;
    endcase
  end

endmodule

// [sbta_cap_in.sv]
// capture input: source select, optional noise filter, edge detector
`timescale 1ns/1ns
module sbta_cap_in
  import sbta_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic capture_pin,
  input wire logic comparator_out,
  input wire logic use_comparator,
  input wire logic filter_on,
  input wire logic rising,
  output logic capture_event
);
  import sbta_pkg::*;

  logic pin1_r, pin2_r, cmp1_r, cmp2_r, level_r, prev_r;
  logic [FILT_LEN-1:0] hist_r;
  logic src, steady, level_nxt;

  assign src = use_comparator ? cmp2_r : pin2_r;
  // filtered level moves only after the full history agrees
  assign steady = (&hist_r) || !(|hist_r);
  assign level_nxt = filter_on ? (steady ? hist_r[0] : level_r) : src;
  assign capture_event = ce && (rising ? (level_r && !prev_r) : (!level_r && prev_r));

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin1_r <= 1'b0;
      pin2_r <= 1'b0;
      cmp1_r <= 1'b0;
      cmp2_r <= 1'b0;
      hist_r <= '0;
      level_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else if (ce)
    begin
      pin1_r <= capture_pin;
      pin2_r <= pin1_r;
      cmp1_r <= comparator_out;
      cmp2_r <= cmp1_r;
      hist_r <= {hist_r[FILT_LEN-2:0], src};
      level_r <= level_nxt;
      prev_r <= level_r;
    end
  end

endmodule

// [sbta_top.sv]
// sixteen-bit timer with byte-wide register access over an axi4-lite slave
`timescale 1ns/1ns
module sbta_top
  import sbta_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_count_pin,
  input wire logic capture_pin,
  input wire logic comparator_out,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic irq_request
);
  import sbta_pkg::*;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a);
    return (a[7:6] == 2'b00) && (a[5:2] <= IDX_LAST);
  endfunction

  function automatic logic mode_pwm(input logic [3:0] m);
    return m[3] ? (m[3:1] == 3'b111) : (m[1:0] != 2'b00);
  endfunction

  function automatic logic [15:0] peak_of(input logic [3:0] m, input logic [15:0] ca,
                                          input logic [15:0] cap);
    unique case (m)
      4'h1, 4'h5: return PEAK_8;
      4'h2, 4'h6: return PEAK_9;
      4'h3, 4'h7: return PEAK_10;
      4'h4, 4'hF: return ca;
      4'hC, 4'hE: return cap;
      default: return COUNT_MAX;
    endcase
  endfunction

  function automatic logic wave_next(input logic cur, input logic [1:0] com, input logic pwm,
                                     input logic match, input logic wrap);
    logic v;
    v = cur;
    if (!pwm)
    begin
      if (match && com == 2'b01)
        v = !cur;
      else if (match && com[1])
        v = com[0];
    end
    else if (com[1])
    begin
      if (wrap)
        v = !com[0];
      else if (match)
        v = com[0];
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_a_r, ctrl_b_r, temp_r, mask_r, temp_nxt;
  logic [3:0] flag_r, flag_nxt, flag_set, flag_clr;
  logic [15:0] count_r, cmpa_buf_r, cmpb_buf_r, cmpa_act_r, cmpb_act_r, capture_r;
  logic [15:0] count_nxt, capture_nxt, peak;
  logic wave_a_r, wave_b_r, bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [7:0] rd_byte;
  logic [31:0] rdata_r;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire wr_fire = ce && s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  wire rd_fire = ce && s_axi_arvalid && !rvalid_r;
  wire [3:0] widx = s_axi_awaddr[5:2];
  wire [3:0] ridx = s_axi_araddr[5:2];
  wire wr_ok = wr_fire && s_axi_wstrb[0] && addr_hit(s_axi_awaddr);
  wire rd_ok = rd_fire && addr_hit(s_axi_araddr);
  wire [7:0] wdat = s_axi_wdata[7:0];
  wire wr_ctrl_a = wr_ok && widx == IDX_CTRL_A;
  wire wr_ctrl_b = wr_ok && widx == IDX_CTRL_B;
  wire wr_cnt_lo = wr_ok && widx == IDX_CNT_LO;
  wire wr_cmpa_lo = wr_ok && widx == IDX_CMPA_LO;
  wire wr_cmpb_lo = wr_ok && widx == IDX_CMPB_LO;
  wire wr_cap_lo = wr_ok && widx == IDX_CAP_LO;
  wire wr_flag = wr_ok && widx == IDX_FLAG;
  wire wr_mask = wr_ok && widx == IDX_MASK;
  // every high-byte write goes to the one shared holding register
  wire wr_temp = wr_ok && widx[0] && widx >= IDX_CNT_HI && widx <= IDX_CAP_HI;
  wire rd_cnt_lo = rd_ok && ridx == IDX_CNT_LO;
  wire rd_cap_lo = rd_ok && ridx == IDX_CAP_LO;

  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_arready = rd_fire;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // ----------------------------------------------------------------
  // mode, peak and clocking
  // ----------------------------------------------------------------
  wire [3:0] mode = {ctrl_b_r[CB_MODE_HI +: 2], ctrl_a_r[CA_MODE_LO +: 2]};
  wire pwm = mode_pwm(mode);
  wire peak_is_cap = (mode == 4'hC) || (mode == 4'hE);
  wire peak_is_a_pwm = pwm && mode == 4'hF;
  wire tick, cap_evt;

  assign peak = peak_of(mode, cmpa_act_r, capture_r);

  sbta_clk_sel u_clk_sel (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .clk_select(ctrl_b_r[CB_CLK_SEL +: 3]),
    .ext_count_pin(ext_count_pin),
    .tick(tick)
  );

  sbta_cap_in u_cap_in (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .capture_pin(capture_pin),
    .comparator_out(comparator_out),
    .use_comparator(ctrl_b_r[CB_CAP_SRC]),
    .filter_on(ctrl_b_r[CB_FILTER]),
    .rising(ctrl_b_r[CB_CAP_EDGE]),
    .capture_event(cap_evt)
  );

  // ----------------------------------------------------------------
  // counter, compare and capture next values
  // ----------------------------------------------------------------
  wire at_peak = count_r == peak;
  wire wrap = tick && at_peak;
  wire match_a = tick && count_r == cmpa_act_r;
  wire match_b = tick && count_r == cmpb_act_r;
  wire ovf = pwm ? wrap : (tick && count_r == COUNT_MAX);
  wire cap_take = cap_evt && !peak_is_cap;
  wire reload = !pwm || wrap;

  // a counter write overrides wrap and count
  assign count_nxt = wr_cnt_lo ? {temp_r, wdat} : (wrap ? COUNT_FLOOR :
                     (tick ? count_r + 16'h0001 : count_r));
  assign capture_nxt = (wr_cap_lo && peak_is_cap) ? {temp_r, wdat} :
                       (cap_take ? count_r : capture_r);
  assign flag_set = {cap_take, match_b, match_a, ovf};
  assign flag_clr = wr_flag ? wdat[3:0] : 4'h0;
  assign flag_nxt = (flag_r & ~flag_clr) | flag_set;
  assign temp_nxt = wr_temp ? wdat : (rd_cnt_lo ? count_r[15:8] :
                    (rd_cap_lo ? capture_r[15:8] : temp_r));
  assign irq_request = |(flag_r & mask_r[3:0]);
  assign wave_out_a = wave_a_r;
  assign wave_out_b = wave_b_r;

  // ----------------------------------------------------------------
  // read data select
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (ridx)
      IDX_CTRL_A: rd_byte = ctrl_a_r;
      IDX_CTRL_B: rd_byte = ctrl_b_r;
      IDX_CNT_LO: rd_byte = count_r[7:0];
      IDX_CMPA_LO: rd_byte = cmpa_buf_r[7:0];
      IDX_CMPA_HI: rd_byte = cmpa_buf_r[15:8];
      IDX_CMPB_LO: rd_byte = cmpb_buf_r[7:0];
      IDX_CMPB_HI: rd_byte = cmpb_buf_r[15:8];
      IDX_CAP_LO: rd_byte = capture_r[7:0];
      IDX_CNT_HI, IDX_CAP_HI: rd_byte = temp_r;
      IDX_FLAG: rd_byte = {4'h0, flag_r};
      IDX_MASK: rd_byte = mask_r;
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_a_r <= RST_BYTE;
      ctrl_b_r <= RST_BYTE;
      temp_r <= RST_BYTE;
      mask_r <= RST_BYTE;
      flag_r <= 4'h0;
      count_r <= RST_WORD;
      cmpa_buf_r <= RST_WORD;
      cmpb_buf_r <= RST_WORD;
      cmpa_act_r <= RST_WORD;
      cmpb_act_r <= RST_WORD;
      capture_r <= RST_WORD;
      wave_a_r <= 1'b0;
      wave_b_r <= 1'b0;
    end
    else if (ce)
    begin
      ctrl_a_r <= wr_ctrl_a ? wdat : ctrl_a_r;
      ctrl_b_r <= wr_ctrl_b ? wdat : ctrl_b_r;
      mask_r <= wr_mask ? {4'h0, wdat[3:0]} : mask_r;
      temp_r <= temp_nxt;
      flag_r <= flag_nxt;
      count_r <= count_nxt;
      capture_r <= capture_nxt;
      cmpa_buf_r <= wr_cmpa_lo ? {temp_r, wdat} : cmpa_buf_r;
      cmpb_buf_r <= wr_cmpb_lo ? {temp_r, wdat} : cmpb_buf_r;
      // pwm modes take new compare values, and so a compare a peak, only at the wrap
      cmpa_act_r <= reload ? cmpa_buf_r : cmpa_act_r;
      cmpb_act_r <= reload ? cmpb_buf_r : cmpb_act_r;
      wave_a_r <= peak_is_a_pwm ? 1'b0 :
                  wave_next(wave_a_r, ctrl_a_r[CA_COM_A +: 2], pwm, match_a, wrap);
      wave_b_r <= wave_next(wave_b_r, ctrl_a_r[CA_COM_B +: 2], pwm, match_b, wrap);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end
    else if (ce)
    begin
      if (wr_fire)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= addr_hit(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_r <= 1'b0;
      if (rd_fire)
      begin
        rvalid_r <= 1'b1;
        rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        rdata_r <= rd_ok ? {24'h000000, rd_byte} : 32'h0000_0000;
      end
      else if (s_axi_rready)
        rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_low_write_load: assert property (@(posedge clk) disable iff (sys_rst)
    wr_cnt_lo |=> count_r == {$past(temp_r), $past(wdat)})
    else $error("counter low write did not load both bytes");
  a_read_temp_copy: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_cnt_lo && !wr_temp) |=> temp_r == $past(count_r[15:8]))
    else $error("counter low read did not copy the high byte");
  a_cmp_read_keep: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_ok && ridx >= IDX_CMPA_LO && ridx <= IDX_CMPB_HI && !wr_temp) |=> $stable(temp_r))
    else $error("compare read disturbed the holding register");
  a_count_idle: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_b_r[2:0] == 3'h0 && !wr_cnt_lo) [*2] |=> $stable(count_r))
    else $error("counter moved with no clock selected");
  a_match_sets: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && match_b) |=> flag_r[FL_MATCH_B])
    else $error("compare b match did not set its flag");
  a_capture_same: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && cap_take) |=> (capture_r == $past(count_r)) && flag_r[FL_CAPTURE])
    else $error("capture value and flag not set together");
  a_floor_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    (wrap && !wr_cnt_lo) |=> count_r == COUNT_FLOOR)
    else $error("counter did not return to the floor at the peak");
  a_fixed_peak: assert property (@(posedge clk) disable iff (sys_rst)
    (mode == 4'h2 || mode == 4'h6) |-> peak == PEAK_9)
    else $error("nine-bit peak not selected");
  a_peak_a_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && peak_is_a_pwm) [*2] |-> !wave_out_a)
    else $error("wave a driven while compare a is the peak");
  a_irq_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && ovf && mask_r[FL_OVF]) |=> irq_request)
    else $error("masked-in overflow raised no request");
  a_write_wins: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_cnt_lo && tick) |=> count_r == {$past(temp_r), $past(wdat)})
    else $error("counting overrode a counter write");
  a_temp_reset: assert property (@(posedge clk)
    $past(sys_rst) && !sys_rst |-> temp_r == 8'h00)
    else $error("holding register not zero after reset");
  a_ctrl_free: assert property (@(posedge clk) disable iff (sys_rst)
    wr_ctrl_b |=> ctrl_b_r == $past(wdat))
    else $error("control b write not stored");
  a_wave_toggle: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && !pwm && match_b && ctrl_a_r[CA_COM_B +: 2] == 2'b01) |=> wave_out_b != $past(wave_out_b))
    else $error("wave b did not toggle on match");

endmodule

// [sbta_cpu_model.sv]
// cpu side model: byte-wide register access over axi4-lite
`timescale 1ns/1ns
module sbta_cpu_model (
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  int n;
  // responses are always accepted at once
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} = '0;
    {bready, rready} = 2'b11;
  end
  // ----------------------------------------------------------------
  // bus cycles; one caller at a time, so no pair is ever interleaved
  // ----------------------------------------------------------------
  task tmo;
    if (n >= 200)
    begin
      testbench.errors++;
      testbench.report_and_stop();
    end
  endtask
  task wr(input logic [3:0] i, input logic [7:0] d, output logic [1:0] r);
    awaddr <= {2'b00, i, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do @(posedge clk); while (!(awready === 1'b1 && wready === 1'b1) && ++n < 200);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1 && ++n < 200);
    r = bresp;
    tmo();
  endtask
  task rd(input logic [3:0] i, output logic [7:0] d, output logic [1:0] r);
    araddr <= {2'b00, i, 2'b00};
    arvalid <= 1'b1;
    n = 0;
    do @(posedge clk); while (arready !== 1'b1 && ++n < 200);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1 && ++n < 200);
    d = rdata[7:0];
    r = rresp;
    tmo();
  endtask
endmodule

// [testbench.sv]
// self-checking bench for the sixteen-bit timer
`timescale 1ns/1ns
module testbench;
  import sbta_pkg::*;
  logic clk, sys_rst, ext_count_pin, capture_pin, comparator_out;
  logic [7:0] awaddr, araddr, v;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, wave_out_a, wave_out_b, irq_request;
  int errors = 0;
  int n_checks = 0;
  always #50 clk = ~clk;
  sbta_top u_sbta_top (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_count_pin(ext_count_pin), .capture_pin(capture_pin),
    .comparator_out(comparator_out), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .irq_request(irq_request));
  sbta_cpu_model u_sbta_cpu_model (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [3:0] i, input logic [7:0] d);
    u_sbta_cpu_model.wr(i, d, rs);
  endtask
  task rd(input logic [3:0] i);
    u_sbta_cpu_model.rd(i, v, rs);
  endtask
  task w16(input logic [3:0] hi, input logic [15:0] d);
    wr(hi, d[15:8]);
    wr(hi - 4'h1, d[7:0]);
  endtask
  task pulse(input int k);
    repeat (k)
    begin
      ext_count_pin <= 1'b1;
      repeat (4) @(posedge clk);
      ext_count_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_hold;
    rd(IDX_CNT_HI);
    chk("hold reset", v, 8'h00);
    w16(IDX_CNT_HI, 16'h1234);
    rd(IDX_CNT_LO);
    chk("cnt lo", v, 8'h34);
    rd(IDX_CNT_HI);
    chk("cnt hi", v, 8'h12);
    w16(IDX_CMPA_HI, 16'hABCD);
    rd(IDX_CMPA_LO);
    chk("cmpa lo", v, 8'hCD);
    rd(IDX_CNT_LO);
    rd(IDX_CMPA_HI);
    chk("cmpa hi", v, 8'hAB);
    rd(IDX_CNT_HI);
    chk("hold kept", v, 8'h12);
    wr(IDX_CNT_HI, 8'h56);
    wr(IDX_CMPB_LO, 8'h78);
    rd(IDX_CMPB_HI);
    chk("shared hold", v, 8'h56);
  endtask
  task t_regs;
    wr(IDX_CTRL_A, 8'hF0);
    wr(IDX_CTRL_B, 8'h98);
    rd(IDX_CTRL_A);
    chk("ctrl a", v, 8'hF0);
    rd(IDX_CTRL_B);
    chk("ctrl b", v, 8'h98);
    rd(4'hC);
    chk("unmapped", {v, rs}, {8'h00, RESP_SLVERR});
    wr(IDX_CTRL_A, 8'h00);
    wr(IDX_CTRL_B, 8'h00);
  endtask
  task t_ext;
    w16(IDX_CNT_HI, 16'h0000);
    pulse(2);
    wr(IDX_CTRL_B, {5'h00, CS_EXT_RISE});
    pulse(4);
    repeat (6) @(posedge clk);
    wr(IDX_CTRL_B, 8'h00);
    rd(IDX_CNT_LO);
    chk("ext count", v, 8'h04);
  endtask
  task t_flags;
    wr(IDX_FLAG, 8'h0F);
    w16(IDX_CMPA_HI, 16'h0005);
    w16(IDX_CMPB_HI, 16'h0008);
    w16(IDX_CNT_HI, 16'hFFF0);
    wr(IDX_CTRL_A, 8'h50);
    wr(IDX_MASK, 8'h01);
    wr(IDX_CTRL_B, 8'h01);
    repeat (40) @(posedge clk);
    wr(IDX_CTRL_B, 8'h00);
    rd(IDX_FLAG);
    chk("flags", v, 8'h07);
    chk("wave a", wave_out_a, 1'b1);
    chk("wave b", wave_out_b, 1'b1);
    chk("irq on", irq_request, 1'b1);
    wr(IDX_MASK, 8'h08);
    chk("irq masked", irq_request, 1'b0);
    wr(IDX_FLAG, 8'h07);
    rd(IDX_FLAG);
    chk("flags clr", v, 8'h00);
    wr(IDX_CTRL_A, 8'h00);
  endtask
  task t_peak;
    logic [15:0] pk;
    for (int m = 1; m <= 3; m++)
    begin
      pk = (m == 1) ? PEAK_8 : ((m == 2) ? PEAK_9 : PEAK_10);
      wr(IDX_FLAG, 8'h0F);
      w16(IDX_CNT_HI, pk - 16'h000F);
      wr(IDX_CTRL_A, m[7:0]);
      wr(IDX_CTRL_B, 8'h01);
      repeat (30) @(posedge clk);
      wr(IDX_CTRL_B, 8'h00);
      rd(IDX_CNT_LO);
      rd(IDX_CNT_HI);
      chk("peak wrap", v, 8'h00);
      rd(IDX_FLAG);
      chk("peak ovf", v[0], 1'b1);
    end
    wr(IDX_CTRL_A, 8'h00);
  endtask
  // compare a as peak in pwm: wave a forced low, count wraps at compare a
  task t_top_a;
    w16(IDX_CMPA_HI, 16'h0010);
    w16(IDX_CNT_HI, 16'h0000);
    wr(IDX_FLAG, 8'h0F);
    wr(IDX_CTRL_A, 8'hC3);
    wr(IDX_CTRL_B, 8'h19);
    repeat (40) @(posedge clk);
    wr(IDX_CTRL_B, 8'h00);
    chk("top a quiet", wave_out_a, 1'b0);
    rd(IDX_CNT_LO);
    chk("top a wrap", v <= 8'h10, 1'b1);
    rd(IDX_FLAG);
    chk("top a ovf", v[0], 1'b1);
    wr(IDX_CTRL_A, 8'h00);
  endtask
  task t_prio;
    wr(IDX_CTRL_B, 8'h01);
    w16(IDX_CNT_HI, 16'h3000);
    rd(IDX_CNT_LO);
    rd(IDX_CNT_HI);
    wr(IDX_CTRL_B, 8'h00);
    chk("write wins", v, 8'h30);
  endtask
  task t_cap;
    logic [7:0] cb;
    for (int i = 0; i < 3; i++)
    begin
      cb = (i == 0) ? 8'h41 : ((i == 1) ? 8'h61 : 8'hC1);
      w16(IDX_CNT_HI, {i[7:0] + 8'h01, 8'h00});
      wr(IDX_FLAG, 8'h0F);
      wr(IDX_CTRL_B, cb);
      if (i == 1)
        comparator_out <= 1'b1;
      else
        capture_pin <= 1'b1;
      repeat (12) @(posedge clk);
      capture_pin <= 1'b0;
      comparator_out <= 1'b0;
      repeat (12) @(posedge clk);
      wr(IDX_CTRL_B, 8'h00);
      rd(IDX_FLAG);
      chk("cap flag", v[3], 1'b1);
      rd(IDX_CAP_LO);
      rd(IDX_CAP_HI);
      chk("cap value", v, i[7:0] + 8'h01);
    end
  endtask
  initial
  begin
    {clk, ext_count_pin, capture_pin, comparator_out} = 4'h0;
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_hold();
    t_regs();
    t_ext();
    t_flags();
    t_peak();
    t_top_a();
    t_prio();
    t_cap();
    report_and_stop();
  end
endmodule
